/* File: ee_dev.sv */
/*
 * device end: byte-organised eeprom behind a mode-0 serial link, with
 * read, page write, write-enable latch, status read and a self-timed
 * programming cycle. the array is held in flip-flops.
 * assumes link pins are synchronous to clk_sys and that sck is slow
 * enough that every level lasts at least two clk_sys cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module ee_dev
  import ee_pkg::*;
#(
  parameter int ADDR_W    = `EE_ADDR_W_MIN,
  parameter int WC_CYCLES = `EE_WC_CYCLES
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // link
  ee_link_if.dev          link,
  // protection level and state
  input  wire logic [1:0] bp_level,
  output logic            busy,
  output logic            wel
);
  localparam int PB    = `EE_PAGE_BITS;
  localparam int PAGE  = 1 << PB;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int WC_W  = $clog2(WC_CYCLES + 1);

  if (ADDR_W < `EE_ADDR_W_MIN || ADDR_W > `EE_ADDR_W_MAX) begin : g_bad_aw
    $error("ee_dev: ADDR_W out of range");
  end
  if (WC_CYCLES < 1) begin : g_bad_wc
    $error("ee_dev: WC_CYCLES must be at least 1");
  end

  // bit 3 of an opcode is a don't-care
  function automatic logic op_match(input logic [7:0] b,
                                    input logic [7:0] code);
    logic [7:0] m;
    m = 8'hff;
    m[`EE_OP_DONT_CARE] = 1'b0;
    op_match = (b & m) == (code & m);
  endfunction : op_match

  // level 1 covers the top quarter, level 2 the top half, 3 all
  function automatic logic is_prot(input logic [ADDR_W-1:0] a,
                                   input logic [1:0] lvl);
    case (lvl)
      2'd1:    is_prot = &a[ADDR_W-1 -: 2];
      2'd2:    is_prot = a[ADDR_W-1];
      2'd3:    is_prot = 1'b1;
      default: is_prot = 1'b0;
    endcase
  endfunction : is_prot

  dev_state_e        st_q;
  logic              sck_q;
  logic              cs_n_q;
  logic [2:0]        bit_q;
  logic [7:0]        sr_q;
  logic              rd_q;
  logic              ahi_q;
  logic [7:0]        ah_q;
  logic [ADDR_W-1:0] ad_q;
  logic [7:0]        tx_q;
  logic              so_q;
  logic              so_oe_q;
  logic              wel_q;
  logic              busy_q;
  logic              loaded_q;
  logic [PAGE-1:0]   pvld_q;
  logic [WC_W-1:0]   wc_q;
  logic [7:0]        mem  [DEPTH];
  logic [7:0]        pbuf [PAGE];

  // ****************************************************************
  // decode
  // ****************************************************************
  wire        sel       = ~link.cs_n;
  wire        sck_rise  = sel & link.sck & ~sck_q;
  wire        sck_fall  = sel & ~link.sck & sck_q;
  wire        cs_rise   = link.cs_n & ~cs_n_q;
  wire        byte_done = sck_rise && bit_q == 3'h7;
  wire [7:0]  byte_in   = {sr_q[6:0], link.mosi};
  wire [15:0] full_addr = {ah_q, byte_in};
  wire [ADDR_W-1:0] new_ad = full_addr[ADDR_W-1:0];
  wire        wc_end    = busy_q && wc_q == WC_W'(WC_CYCLES - 1);
  wire        prog_go   = cs_rise && st_q == DS_WDATA &&
                          loaded_q && bit_q == 3'h0;
  wire [7:0]  stat      = busy_q ? `EE_ST_WHILE_BUSY :
                          {4'h0, bp_level, wel_q, busy_q};
  wire        is_rd     = op_match(byte_in, `EE_OP_READ);
  wire        is_wr     = op_match(byte_in, `EE_OP_WRITE);
  wire        is_enable = op_match(byte_in, `EE_OP_WRITE_ENABLE);
  wire        is_status = op_match(byte_in, `EE_OP_STATUS_READ);
  wire        addr_fin  = st_q == DS_ADDR && byte_done && ahi_q;
  wire        wr_byte   = st_q == DS_WDATA && byte_done;

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q     <= DS_CMD;
      sck_q    <= 1'b0;
      cs_n_q   <= 1'b1;
      bit_q    <= 3'h0;
      sr_q     <= 8'h00;
      rd_q     <= 1'b0;
      ahi_q    <= 1'b0;
      ah_q     <= 8'h00;
      ad_q     <= '0;
      tx_q     <= 8'h00;
      loaded_q <= 1'b0;
    end else begin
      sck_q  <= link.sck;
      cs_n_q <= link.cs_n;
      if (!sel) begin
        // deselect ends any transfer; the next fall starts fresh
        st_q     <= DS_CMD;
        bit_q    <= 3'h0;
        loaded_q <= 1'b0;
      end else if (sck_rise) begin
        bit_q <= bit_q + 3'h1;
        sr_q  <= byte_in;
        if (byte_done) begin
          case (st_q)
            DS_CMD: begin
              ahi_q <= 1'b0;
              if (busy_q) begin
                st_q <= is_status ? DS_STAT : DS_IGNORE;
              end else if (is_rd) begin
                st_q <= DS_ADDR;
                rd_q <= 1'b1;
              end else if (is_wr) begin
                st_q <= wel_q ? DS_ADDR : DS_IGNORE;
                rd_q <= 1'b0;
              end else if (is_status) begin
                st_q <= DS_STAT;
              end else begin
                st_q <= DS_IGNORE;
              end
              tx_q <= stat;
            end
            DS_ADDR: begin
              ahi_q <= 1'b1;
              ah_q  <= byte_in;
              if (ahi_q && rd_q) begin
                st_q <= DS_RDATA;
                tx_q <= mem[new_ad];
                ad_q <= new_ad + ADDR_W'(1);
              end else if (ahi_q) begin
                st_q <= DS_WDATA;
                ad_q <= new_ad;
              end
            end
            DS_RDATA: begin
              // mosi is not looked at here
              tx_q <= mem[ad_q];
              ad_q <= ad_q + ADDR_W'(1);
            end
            DS_WDATA: begin
              loaded_q <= 1'b1;
              ad_q[PB-1:0] <= ad_q[PB-1:0] + PB'(1);
            end
            DS_STAT: tx_q <= stat;
            default: st_q <= st_q;
          endcase
        end
      end else if (sck_fall &&
                   (st_q == DS_RDATA || st_q == DS_STAT)) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // serial output, data changes only after a falling sck or on deselect
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !sel) begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= 1'b1;
      if (sck_fall && (st_q == DS_RDATA || st_q == DS_STAT)) begin
        so_q <= tx_q[7];
      end
    end
  end

  // ****************************************************************
  // write-enable latch and programming timer
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wel_q  <= 1'b0;
      busy_q <= 1'b0;
      wc_q   <= '0;
    end else begin
      if (prog_go) begin
        busy_q <= 1'b1;
        wc_q   <= '0;
      end else if (wc_end) begin
        busy_q <= 1'b0;
        wel_q  <= 1'b0;
      end else if (busy_q) begin
        wc_q <= wc_q + WC_W'(1);
      end
      if (byte_done && st_q == DS_CMD && !busy_q && is_enable) begin
        wel_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // page buffer and array; storage carries no reset
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n || addr_fin) begin
      pvld_q <= '0;
    end else if (wr_byte) begin
      pvld_q[ad_q[PB-1:0]] <= 1'b1;
    end else if (wc_end) begin
      pvld_q <= '0;
    end
  end

  // a whole page lands in one cycle when the timer expires, so reads
  // never see a half-written page; one process owns the whole array
  always_ff @(posedge clk_sys) begin
    if (wr_byte) begin
      pbuf[ad_q[PB-1:0]] <= byte_in;
    end
    for (int i = 0; i < PAGE; i++) begin
      if (wc_end && pvld_q[i] &&
          !is_prot({ad_q[ADDR_W-1:PB], PB'(i)}, bp_level)) begin
        mem[{ad_q[ADDR_W-1:PB], PB'(i)}] <= pbuf[i];
      end
    end
  end

  assign link.miso    = so_q;
  assign link.miso_oe = so_oe_q;
  assign busy         = busy_q;
  assign wel          = wel_q;
endmodule : ee_dev
`default_nettype wire

/* File: ee_host.sv */
/*
 * host end: runs one selected transfer per request, making the serial
 * clock from clk_sys with a divider.
 * assumes the user holds op, addr, len and wdata stable while busy and
 * moves wdata on to the next byte after each wdata_take pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module ee_host
  import ee_pkg::*;
#(
  parameter int SCK_HALF = `EE_SCK_HALF_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // link
  ee_link_if.host          link,
  // request
  input  wire logic        req,
  input  wire op_e         op,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] len,
  input  wire logic [7:0]  wdata,
  // answer
  output logic             busy,
  output logic             wdata_take,
  output logic [7:0]       rdata,
  output logic             rdata_vld,
  output logic             done
);
  localparam int DIV_W = $clog2(SCK_HALF + 1);

  if (SCK_HALF < 2) begin : g_bad_div
    $error("ee_host: SCK_HALF must be at least 2");
  end

  host_state_e      st_q;
  op_e              op_q;
  logic [15:0]      addr_q;
  logic [16:0]      idx_q;
  logic [16:0]      last_q;
  logic [2:0]       bit_q;
  logic [7:0]       tx_q;
  logic [7:0]       rx_q;
  logic [DIV_W-1:0] div_q;
  logic             cs_n_q;
  logic             sck_q;
  logic             mosi_q;
  logic             take_q;
  logic             vld_q;
  logic             done_q;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire        tick     = (st_q != HS_IDLE) &&
                         (div_q == DIV_W'(SCK_HALF - 1));
  wire [16:0] idx_nx   = idx_q + 17'h1;
  wire        is_wr    = (op_q == OP_WRITE);
  wire        has_addr = (op_q == OP_READ) || is_wr;
  wire [7:0]  nb       = (has_addr && idx_nx == 17'h1) ? addr_q[15:8] :
                         (has_addr && idx_nx == 17'h2) ? addr_q[7:0]  :
                         is_wr ? wdata : 8'h00;
  wire        cap      = ((op_q == OP_READ) && idx_q >= 17'h3) ||
                         ((op_q == OP_STATUS_READ) && idx_q >= 17'h1);
  wire [7:0]  op_code  = (op == OP_READ)  ? `EE_OP_READ  :
                         (op == OP_WRITE) ? `EE_OP_WRITE :
                         (op == OP_WRITE_ENABLE) ? `EE_OP_WRITE_ENABLE :
                         `EE_OP_STATUS_READ;
  wire [16:0] last_nx  = (op == OP_WRITE_ENABLE) ? 17'h0 :
                         (op == OP_STATUS_READ) ? {1'b0, len} :
                         17'({1'b0, len} + 17'h2);

  // ****************************************************************
  // divider
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n || st_q == HS_IDLE || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // ****************************************************************
  // transfer sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    take_q <= 1'b0;
    vld_q  <= 1'b0;
    done_q <= 1'b0;
    if (!rst_n) begin
      st_q   <= HS_IDLE;
      op_q   <= OP_READ;
      addr_q <= 16'h0000;
      idx_q  <= 17'h0;
      last_q <= 17'h0;
      bit_q  <= 3'h0;
      tx_q   <= 8'h00;
      rx_q   <= 8'h00;
      cs_n_q <= 1'b1;
      sck_q  <= 1'b0;
      mosi_q <= 1'b0;
    end else begin
      case (st_q)
        HS_IDLE: begin
          if (req) begin
            // each request opens its own selected transfer
            st_q   <= HS_SHIFT;
            op_q   <= op;
            addr_q <= addr;
            last_q <= last_nx;
            idx_q  <= 17'h0;
            bit_q  <= 3'h0;
            tx_q   <= op_code;
            mosi_q <= op_code[7];
            cs_n_q <= 1'b0;
          end
        end
        HS_SHIFT: begin
          if (tick && !sck_q) begin
            // rising edge: the device samples mosi, we sample miso
            sck_q <= 1'b1;
            rx_q  <= {rx_q[6:0], link.miso};
            if (bit_q == 3'h7 && cap) begin
              rdata <= {rx_q[6:0], link.miso};
              vld_q <= 1'b1;
            end
          end else if (tick) begin
            sck_q <= 1'b0;
            if (bit_q != 3'h7) begin
              bit_q  <= bit_q + 3'h1;
              tx_q   <= {tx_q[6:0], 1'b0};
              mosi_q <= tx_q[6];
            end else if (idx_q == last_q) begin
              st_q <= HS_DESEL;
            end else begin
              idx_q  <= idx_nx;
              bit_q  <= 3'h0;
              tx_q   <= nb;
              mosi_q <= nb[7];
              take_q <= is_wr && idx_nx >= 17'h3;
            end
          end
        end
        HS_DESEL: begin
          // still in the low phase after the last bit
          if (tick) begin
            cs_n_q <= 1'b1;
            done_q <= 1'b1;
            st_q   <= HS_IDLE;
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  assign link.cs_n  = cs_n_q;
  assign link.sck   = sck_q;
  assign link.mosi  = mosi_q;
  assign busy       = cs_n_q == 1'b0;
  assign wdata_take = take_q;
  assign rdata_vld  = vld_q;
  assign done       = done_q;
endmodule : ee_host
`default_nettype wire

/* File: ee_link_asserts.sv */
/*
 * concurrent checks on the serial link between host and eeprom ends.
 * assumes the testbench instantiates it beside the link interface and
 * hands on the serial clock half period used by the host.
 */
`timescale 1ns/1ps
`default_nettype none
module ee_link_asserts #(
  parameter int SCK_HALF = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // ****************************************************************
  // helper counters
  // ****************************************************************
  logic [7:0]  hi_cnt_q;
  logic [15:0] bit_cnt_q;
  logic        sck_q;
  wire         sck_rise = sck && !sck_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hi_cnt_q  <= 8'h00;
      bit_cnt_q <= 16'h0000;
      sck_q     <= 1'b0;
    end else begin
      hi_cnt_q  <= sck ? hi_cnt_q + 8'h01 : 8'h00;
      bit_cnt_q <= cs_n ? 16'h0000 : bit_cnt_q + {15'h0000, sck_rise};
      sck_q     <= sck;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // assertions
  // ****************************************************************
  // two cycles of slack cover a synchroniser on the select input
  miso_idle_a: assert property (cs_n && $past(cs_n) && $past(cs_n, 2)
    |-> !miso_oe && !miso) else $error("miso driven while deselected");
  oe_follow_a: assert property (!cs_n && !$past(cs_n) && !$past(cs_n, 2)
    |-> miso_oe) else $error("miso not driven while selected");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock not low while deselected");
  sel_start_a: assert property ($fell(cs_n) |-> !sck && !$past(sck))
    else $error("select fell with serial clock high");
  miso_hold_a: assert property (!cs_n && sck && $past(sck) |-> $stable(miso))
    else $error("miso changed in serial clock high phase");
  mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("mosi changed in serial clock high phase");
  desel_low_a: assert property ($rose(cs_n) |-> !$past(sck) && !$past(sck, 2))
    else $error("select rose outside serial clock low phase");
  high_phase_a: assert property ($fell(sck) |-> hi_cnt_q == 8'(SCK_HALF))
    else $error("serial clock high phase of wrong length");
  whole_bytes_a: assert property ($rose(cs_n)
    |-> bit_cnt_q[2:0] == 3'h0 && bit_cnt_q != 16'h0000)
    else $error("transfer ended on a partial byte");
endmodule : ee_link_asserts
`default_nettype wire

/* File: ee_link_if.sv */
/*
 * four-wire mode-0 serial link between the host and the eeprom.
 * assumes the testbench resolves the shared output pin from miso_oe.
 */
`timescale 1ns/1ps
`default_nettype none
interface ee_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport dev  (input cs_n, input sck, input mosi,
                output miso, output miso_oe);
  modport host (output cs_n, output sck, output mosi,
                input miso, input miso_oe);
endinterface : ee_link_if
`default_nettype wire

/* File: ee_link_regs.svh */
/*
 * constants for the serial eeprom link: opcodes, status bits, page
 * geometry and timing counts.
 * assumes it is included by bare name from the package and modules.
 */
`ifndef EE_LINK_REGS_SVH
`define EE_LINK_REGS_SVH

// ****************************************************************
// opcodes, compared on bits 7:4 and 2:0 only
// ****************************************************************
`define EE_OP_READ        8'h03
`define EE_OP_WRITE       8'h02
`define EE_OP_WRITE_ENABLE 8'h06
`define EE_OP_STATUS_READ 8'h05
`define EE_OP_DONT_CARE   3

// ****************************************************************
// status byte
// ****************************************************************
`define EE_ST_BUSY_BIT    0
`define EE_ST_WEL_BIT     1
`define EE_ST_BP_LSB      2
`define EE_ST_WHILE_BUSY  8'hff

// ****************************************************************
// geometry
// ****************************************************************
`define EE_PAGE_BITS      5
`define EE_ADDR_W_MIN     10
`define EE_ADDR_W_MAX     13

// ****************************************************************
// timing
// ****************************************************************
`define EE_CLK_MHZ        250
`define EE_T_WC_MS        5
`define EE_WC_CYCLES      (`EE_T_WC_MS * 1000 * `EE_CLK_MHZ)
`define EE_T_SCK_HALF_NS  100
`define EE_SCK_HALF_CYC   ((`EE_T_SCK_HALF_NS * `EE_CLK_MHZ + 999) / 1000)

`endif

/* File: ee_pkg.sv */
/*
 * types shared by both ends of the serial eeprom link.
 * assumes ee_link_regs.svh is on the include path.
 */
`default_nettype none
package ee_pkg;
  `include "ee_link_regs.svh"

  typedef enum logic [1:0] {
    OP_READ, OP_WRITE, OP_WRITE_ENABLE, OP_STATUS_READ
  } op_e;

  typedef enum logic [2:0] {
    DS_CMD, DS_ADDR, DS_RDATA, DS_WDATA, DS_STAT, DS_IGNORE
  } dev_state_e;

  typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_DESEL} host_state_e;
endpackage : ee_pkg
`default_nettype wire

/* File: tb_spi_eeprom_read_write_sequencer.sv */
/*
 * self-checking bench: host end and eeprom end joined by the link.
 * assumes the design files and the link checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_spi_eeprom_read_write_sequencer;
  import ee_pkg::*;
  localparam int H = 2;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        req     = 1'b0;
  op_e         op      = OP_STATUS_READ;
  logic [15:0] addr    = 16'h0000;
  logic [15:0] len     = 16'h0001;
  logic [7:0]  wdata   = 8'h00;
  logic [1:0]  bp_level = 2'b00;
  logic        wdata_take, rdata_vld, done, dev_busy, wel, host_busy;
  logic [7:0]  rdata;
  logic [7:0]  wq[$];
  logic [7:0]  rq[$];
  int          fail_count = 0;
  int          n_tests    = 0;

  always #2 clk_sys = ~clk_sys;

  ee_link_if link ();
  ee_host #(.SCK_HALF(H)) i_ee_host (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link.host), .req(req), .op(op), .addr(addr), .len(len),
    .wdata(wdata), .busy(host_busy), .wdata_take(wdata_take), .rdata(rdata),
    .rdata_vld(rdata_vld), .done(done));
  // short programming cycle so that a status poll can still catch it
  ee_dev #(.ADDR_W(10), .WC_CYCLES(400)) i_ee_dev (.clk_sys(clk_sys),
    .rst_n(rst_n), .link(link.dev), .bp_level(bp_level),
    .busy(dev_busy), .wel(wel));
  ee_link_asserts #(.SCK_HALF(H)) i_ee_link_asserts (.clk_sys(clk_sys),
    .rst_n(rst_n), .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi),
    .miso(link.miso), .miso_oe(link.miso_oe));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic conclude();
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic xfer(input op_e o, input logic [15:0] a,
                      input logic [15:0] n);
    int k;
    rq.delete();
    @(posedge clk_sys);
    op   <= o;
    addr <= a;
    len  <= n;
    req  <= 1'b1;
    if (wq.size() > 0) wdata <= wq.pop_front();
    @(posedge clk_sys);
    req <= 1'b0;
    for (k = 0; k < 4000; k++) begin
      @(posedge clk_sys);
      if (k == 0) chk(8'h01, {7'h00, host_busy});
      if (rdata_vld === 1'b1) rq.push_back(rdata);
      if (wdata_take === 1'b1 && wq.size() > 0) wdata <= wq.pop_front();
      if (done === 1'b1) break;
    end
    if (k == 4000) begin
      fail_count++;
      conclude();
    end
    chk(8'h00, {7'h00, host_busy});
  endtask : xfer

  // polls until idle; write-enable bit is masked as it depends on the case
  task automatic wait_ready();
    int k;
    for (k = 0; k < 60; k++) begin
      xfer(OP_STATUS_READ, 16'h0000, 16'h0001);
      if (rq[0] !== 8'hff) break;
    end
    chk({4'h0, bp_level, 2'b00}, rq[0] & 8'hfd);
  endtask : wait_ready

  task automatic enable();
    xfer(OP_WRITE_ENABLE, 16'h0000, 16'h0000);
    chk(8'h01, {7'h00, wel});
  endtask : enable

  task automatic wr1(input logic [15:0] a, input logic [7:0] d);
    enable();
    wq.push_back(d);
    xfer(OP_WRITE, a, 16'h0001);
    wait_ready();
  endtask : wr1

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic s_status_idle();
    xfer(OP_STATUS_READ, 16'h0000, 16'h0002);
    chk(8'h00, rq[0]);
    chk(8'h00, rq[1]);
  endtask : s_status_idle

  task automatic s_page();
    logic [7:0] exp[32];
    int         i;
    enable();
    for (i = 0; i < 34; i++) begin
      wq.push_back(8'h40 + i[7:0]);
      exp[(30 + i) % 32] = 8'h40 + i[7:0];
    end
    xfer(OP_WRITE, 16'hfc3e, 16'd34);
    for (i = 0; i < 4 && dev_busy !== 1'b1; i++) @(posedge clk_sys);
    chk(8'h01, {7'h00, dev_busy});
    xfer(OP_STATUS_READ, 16'h0000, 16'h0001);
    chk(8'hff, rq[0]);
    wq.push_back(8'h77);
    // enable latch is still set here, so only the busy state stops this
    xfer(OP_WRITE, 16'h03ff, 16'h0001);
    wait_ready();
    chk(8'h00, {7'h00, wel});
    xfer(OP_READ, 16'h8020, 16'd32);
    for (i = 0; i < 32; i++) chk(exp[i], rq[i]);
  endtask : s_page

  task automatic s_wrap_read();
    xfer(OP_READ, 16'h03ff, 16'h0002);
    chk(8'ha5, rq[0]);
    chk(8'h3c, rq[1]);
  endtask : s_wrap_read

  task automatic s_no_write_enable_cmd();
    int k;
    wq.push_back(8'hff);
    xfer(OP_WRITE, 16'h0000, 16'h0001);
    for (k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      chk(8'h00, {7'h00, dev_busy});
    end
    xfer(OP_READ, 16'h0000, 16'h0001);
    chk(8'h3c, rq[0]);
  endtask : s_no_write_enable_cmd

  task automatic s_protect();
    @(posedge clk_sys);
    bp_level <= 2'b01;
    wr1(16'h03ff, 8'h11);
    xfer(OP_READ, 16'h03ff, 16'h0001);
    chk(8'ha5, rq[0]);
    wr1(16'h02ff, 8'h22);
    xfer(OP_READ, 16'h02ff, 16'h0001);
    chk(8'h22, rq[0]);
  endtask : s_protect

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    s_status_idle();
    wr1(16'h03ff, 8'ha5);
    wr1(16'h0000, 8'h3c);
    s_page();
    s_wrap_read();
    s_no_write_enable_cmd();
    s_protect();
    conclude();
  end
endmodule : tb_spi_eeprom_read_write_sequencer
`default_nettype wire
